// file: include/tst_pkg.sv
// Shared constants and types of the transfer, test and wait executor
package ctw_pkg;
   // ==========================================
   // Opcodes
   localparam logic [7:0] OP_ACC_TO_FLAGS = 8'h84;
   localparam logic [7:0] OP_FLAGS_TO_ACC = 8'h85;
   localparam logic [7:0] OP_ACC_TO_INDEX = 8'h97;
   localparam logic [7:0] OP_INDEX_TO_ACC = 8'h9F;
   localparam logic [7:0] OP_STACK_TO_IDX = 8'h95;
   localparam logic [7:0] OP_IDX_TO_STACK = 8'h94;
   localparam logic [7:0] OP_WAIT         = 8'h8F;
   localparam logic [7:0] OP_TEST_DIR     = 8'h3D;
   localparam logic [7:0] OP_TEST_ACC     = 8'h4D;
   localparam logic [7:0] OP_TEST_IDX     = 8'h5D;
   localparam logic [7:0] OP_TEST_IDX_OFS = 8'h6D;
   localparam logic [7:0] OP_TEST_IDX_PTR = 8'h7D;
   localparam logic [7:0] OP_PREFIX       = 8'h9E;
   localparam logic [7:0] OP_TEST_STK_OFS = 8'h6D;

   // ==========================================
   // Cycle counts
   localparam int CYC_ACC_TO_FLAGS     = 2;
   localparam int CYC_XFER_SHORT       = 1;
   localparam int CYC_XFER_STACK       = 2;
   localparam int CYC_WAIT             = 1;
   localparam int CYC_TEST_DIR         = 3;
   localparam int CYC_TEST_REG         = 1;
   localparam int CYC_TEST_IDX_OFS     = 3;
   localparam int CYC_TEST_IDX_PTR     = 2;
   localparam int CYC_TEST_STK_OFS     = 4;

   // ==========================================
   // Flag positions and reset values
   localparam int FLG_V = 7;
   localparam int FLG_H = 4;
   localparam int FLG_I = 3;
   localparam int FLG_N = 2;
   localparam int FLG_Z = 1;
   localparam int FLG_C = 0;
   localparam logic [7:0]  FLG_FIXED_ONES = 8'h60;
   localparam logic [7:0]  RST_FLAGS      = 8'h68;
   localparam logic [7:0]  RST_ACC        = 8'h00;
   localparam logic [15:0] RST_HX         = 16'h0000;
   localparam logic [15:0] RST_STK        = 16'h00FF;
   localparam logic [15:0] RST_PC         = 16'h0000;
   localparam logic [15:0] ONE16          = 16'h0001;

   // ==========================================
   // Types
   typedef enum logic [5:0] {
      ST_OPC  = 6'b00_0001,
      ST_PFX  = 6'b00_0010,
      ST_OFS  = 6'b00_0100,
      ST_MEM  = 6'b00_1000,
      ST_IDLE = 6'b01_0000,
      ST_HALT = 6'b10_0000
   } ctw_state_e;

   typedef enum logic [1:0] {
      AM_DIRECT  = 2'b00,
      AM_IDX_OFS = 2'b01,
      AM_STK_OFS = 2'b10
   } ctw_amode_e;

   typedef struct packed {
      logic [7:0]  acc;
      logic [15:0] hx;
      logic [15:0] stk;
      logic [7:0]  flags;
      logic [15:0] pc;
   } ctw_regs_s;
endpackage : ctw_pkg

// file: rtl/tst_sync3.sv
// Three-stage synchroniser with agreement filter for a pin input
module ctw_sync3
   import ctw_pkg::*;
(
   input  wire logic clk,
   input  wire logic rst_b,
   input  wire logic pin,
   output logic      level
);
   logic [2:0] sh_q;

   // ==========================================
   // Shift chain
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         sh_q <= 3'h0;
      end else begin
         sh_q <= {sh_q[1:0], pin};
      end
   end

   // ==========================================
   // Change counts once stages two and three agree
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         level <= 1'b0;
      end else if (sh_q[1] == sh_q[2]) begin
         level <= sh_q[2];
      end
   end
endmodule : ctw_sync3

// file: rtl/tst_exec.sv
// Executor for register transfers, zero/sign test and wait
// Function
// - Opcode 84 copies the accumulator into the flag register, all six flags, in 2 cycles.
// - Opcode 85 copies the flag register into the accumulator in 1 cycle, flags kept.
// - Opcode 97 copies the accumulator into the low index byte in 1 cycle, flags kept.
// - Opcode 9F copies the low index byte into the accumulator in 1 cycle, flags kept.
// - Opcode 95 loads the index pair with stack pointer plus one in 2 cycles, flags kept.
// - Opcode 94 loads the stack pointer with index pair minus one in 2 cycles, flags kept.
// - The test computes operand minus zero, clears V, sets N and Z, keeps H, I and C.
// - Test forms are 3D in 3, 4D in 1, 5D in 1, 6D in 3, 7D in 2 and 9E6D in 4 cycles.
// - Opcode 8F clears the interrupt mask then halts execution, 1 cycle.
// - Stack offset mode adds one unsigned offset byte after the opcode to the stack pointer.
// - Indexed offset mode adds one offset byte from the stream to the index pair.
// - Indexed mode uses the index pair as address and fetches no operand byte.
// - Direct mode takes one byte as the address; inherent forms take no bytes.
module ctw_exec
   import ctw_pkg::*;
(
   input  wire logic        clk,
   input  wire logic        rst_b,
   input  wire logic [7:0]  mem_rdata,
   input  wire logic        irq_pin,
   input  wire logic [15:0] irq_vector,
   output logic [15:0]      mem_addr,
   output logic             mem_rd,
   output ctw_regs_s        regs,
   output logic             halted,
   output logic             irq_entry,
   output logic             bad_opcode,
   output logic             instr_start
);
   ctw_state_e  st_q, st_d;
   ctw_amode_e  am_q, am_d;
   logic [7:0]  op_q;
   logic [7:0]  acc_q;
   logic [15:0] hx_q;
   logic [15:0] stk_q;
   logic [7:0]  flags_q;
   logic [15:0] pc_q, pc_d;
   logic [15:0] ea_d;
   logic        irq_lvl;
   logic        wake;
   logic        test_now;
   logic [7:0]  test_val;

   function automatic logic known_op(input logic [7:0] op);
      case (op)
         OP_ACC_TO_FLAGS, OP_FLAGS_TO_ACC, OP_ACC_TO_INDEX, OP_INDEX_TO_ACC,
         OP_STACK_TO_IDX, OP_IDX_TO_STACK, OP_WAIT, OP_TEST_DIR, OP_TEST_ACC,
         OP_TEST_IDX, OP_TEST_IDX_OFS, OP_TEST_IDX_PTR, OP_PREFIX: known_op = 1'b1;
         default: known_op = 1'b0;
      endcase
   endfunction : known_op

   ctw_sync3 u_irq_sync (
      .clk   (clk),
      .rst_b (rst_b),
      .pin   (irq_pin),
      .level (irq_lvl)
   );

   assign wake        = (st_q == ST_HALT) && irq_lvl && !flags_q[FLG_I];
   assign instr_start = (st_q == ST_OPC);
   assign regs        = '{acc: acc_q, hx: hx_q, stk: stk_q, flags: flags_q, pc: pc_q};

   // ==========================================
   // Sequencing and address forming
   always_comb begin
      st_d = st_q;
      am_d = am_q;
      pc_d = pc_q;
      ea_d = hx_q;
      case (st_q)
         ST_OPC: begin
            pc_d = pc_q + ONE16;
            case (mem_rdata)
               OP_ACC_TO_FLAGS, OP_STACK_TO_IDX, OP_IDX_TO_STACK: st_d = ST_IDLE;
               OP_WAIT:     st_d = ST_HALT;
               OP_TEST_DIR: begin
                  st_d = ST_OFS;
                  am_d = AM_DIRECT;
               end
               OP_TEST_IDX_OFS: begin
                  st_d = ST_OFS;
                  am_d = AM_IDX_OFS;
               end
               OP_TEST_IDX_PTR: st_d = ST_MEM;
               OP_PREFIX:   st_d = ST_PFX;
               default:     st_d = ST_OPC;
            endcase
         end
         ST_PFX: begin
            pc_d = pc_q + ONE16;
            if (mem_rdata == OP_TEST_STK_OFS) begin
               st_d = ST_OFS;
               am_d = AM_STK_OFS;
            end else begin
               st_d = ST_OPC;
            end
         end
         ST_OFS: begin
            pc_d = pc_q + ONE16;
            st_d = ST_MEM;
            case (am_q)
               AM_DIRECT:  ea_d = {8'h00, mem_rdata};
               AM_IDX_OFS: ea_d = hx_q + {8'h00, mem_rdata};
               AM_STK_OFS: ea_d = stk_q + {8'h00, mem_rdata};
               default:    ea_d = hx_q;
            endcase
         end
         ST_MEM:  st_d = ST_OPC;
         ST_IDLE: st_d = ST_OPC;
         ST_HALT: begin
            if (wake) begin
               st_d = ST_OPC;
               pc_d = irq_vector;
            end
         end
         default: st_d = ST_OPC;
      endcase
   end

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         st_q <= ST_OPC;
         am_q <= AM_DIRECT;
         pc_q <= RST_PC;
      end else begin
         st_q <= st_d;
         am_q <= am_d;
         pc_q <= pc_d;
      end
   end

   // ==========================================
   // Bus address and read strobe
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         mem_addr <= RST_PC;
         mem_rd   <= 1'b1;
      end else begin
         mem_addr <= (st_d == ST_MEM) ? ea_d : pc_d;
         mem_rd   <= (st_d != ST_IDLE) && (st_d != ST_HALT);
      end
   end

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         op_q <= 8'h00;
      end else if (st_q == ST_OPC) begin
         op_q <= mem_rdata;
      end
   end

   // ==========================================
   // Accumulator and index pair
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         acc_q <= RST_ACC;
      end else if (st_q == ST_OPC && mem_rdata == OP_FLAGS_TO_ACC) begin
         acc_q <= flags_q;
      end else if (st_q == ST_OPC && mem_rdata == OP_INDEX_TO_ACC) begin
         acc_q <= hx_q[7:0];
      end
   end

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         hx_q <= RST_HX;
      end else if (st_q == ST_OPC && mem_rdata == OP_ACC_TO_INDEX) begin
         hx_q[7:0] <= acc_q;
      end else if (st_q == ST_IDLE && op_q == OP_STACK_TO_IDX) begin
         hx_q <= stk_q + ONE16;
      end
   end

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         stk_q <= RST_STK;
      end else if (st_q == ST_IDLE && op_q == OP_IDX_TO_STACK) begin
         stk_q <= hx_q - ONE16;
      end
   end

   // ==========================================
   // Flag register
   assign test_now = (st_q == ST_MEM) ||
                     (st_q == ST_OPC && (mem_rdata == OP_TEST_ACC || mem_rdata == OP_TEST_IDX));
   assign test_val = (st_q == ST_MEM) ? mem_rdata :
                     (mem_rdata == OP_TEST_ACC) ? acc_q : hx_q[7:0];

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         flags_q <= RST_FLAGS;
      end else if (st_q == ST_IDLE && op_q == OP_ACC_TO_FLAGS) begin
         flags_q <= acc_q | FLG_FIXED_ONES;
      end else if (test_now) begin
         flags_q[FLG_V] <= 1'b0;
         flags_q[FLG_N] <= test_val[7];
         flags_q[FLG_Z] <= (test_val == 8'h00);
      end else if (st_q == ST_OPC && mem_rdata == OP_WAIT) begin
         flags_q[FLG_I] <= 1'b0;
      end else if (wake) begin
         flags_q[FLG_I] <= 1'b1;
      end
   end

   // ==========================================
   // Status outputs
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         halted     <= 1'b0;
         irq_entry  <= 1'b0;
         bad_opcode <= 1'b0;
      end else begin
         halted     <= (st_d == ST_HALT);
         irq_entry  <= wake;
         bad_opcode <= (st_q == ST_OPC && !known_op(mem_rdata)) ||
                       (st_q == ST_PFX && mem_rdata != OP_TEST_STK_OFS);
      end
   end

   // ==========================================
   // Checks
   chk_acc_flags: assert property (@(posedge clk) disable iff (!rst_b)
      (st_q == ST_OPC && mem_rdata == OP_ACC_TO_FLAGS) |-> ##2
      (flags_q == ($past(acc_q, 2) | FLG_FIXED_ONES) && st_q == ST_OPC))
      else $error("acc to flags wrong value or timing");
   chk_flags_acc: assert property (@(posedge clk) disable iff (!rst_b)
      (st_q == ST_OPC && mem_rdata == OP_FLAGS_TO_ACC) |=>
      (acc_q == $past(flags_q) && $stable(flags_q) && st_q == ST_OPC))
      else $error("flags to acc wrong");
   chk_acc_index: assert property (@(posedge clk) disable iff (!rst_b)
      (st_q == ST_OPC && mem_rdata == OP_ACC_TO_INDEX) |=>
      (hx_q[7:0] == $past(acc_q) && $stable(flags_q) && st_q == ST_OPC))
      else $error("acc to index wrong");
   chk_index_acc: assert property (@(posedge clk) disable iff (!rst_b)
      (st_q == ST_OPC && mem_rdata == OP_INDEX_TO_ACC) |=>
      (acc_q == $past(hx_q[7:0]) && $stable(flags_q)))
      else $error("index to acc wrong");
   chk_stack_index: assert property (@(posedge clk) disable iff (!rst_b)
      (st_q == ST_OPC && mem_rdata == OP_STACK_TO_IDX) |-> ##2
      (hx_q == 16'($past(stk_q, 2) + ONE16) && st_q == ST_OPC))
      else $error("stack to index wrong");
   chk_index_stack: assert property (@(posedge clk) disable iff (!rst_b)
      (st_q == ST_OPC && mem_rdata == OP_IDX_TO_STACK) |-> ##2
      (stk_q == 16'($past(hx_q, 2) - ONE16) && st_q == ST_OPC))
      else $error("index to stack wrong");
   chk_test_flags: assert property (@(posedge clk) disable iff (!rst_b)
      (st_q == ST_OPC && mem_rdata == OP_TEST_ACC) |=>
      (!flags_q[FLG_V] && flags_q[FLG_N] == $past(acc_q[7]) &&
       flags_q[FLG_Z] == ($past(acc_q) == 8'h00) &&
       flags_q[FLG_C] == $past(flags_q[FLG_C]) && flags_q[FLG_H] == $past(flags_q[FLG_H])))
      else $error("test flags wrong");
   chk_stack_test: assert property (@(posedge clk) disable iff (!rst_b)
      (st_q == ST_OPC && mem_rdata == OP_PREFIX) ##1 (mem_rdata == OP_TEST_STK_OFS) |->
      ##1 (st_q == ST_OFS) ##1 (st_q == ST_MEM) ##1 (st_q == ST_OPC))
      else $error("stack offset test timing wrong");
   chk_stack_addr: assert property (@(posedge clk) disable iff (!rst_b)
      (st_q == ST_OFS && am_q == AM_STK_OFS) |=>
      (mem_addr == 16'($past(stk_q) + {8'h00, $past(mem_rdata)})))
      else $error("stack offset address wrong");
   chk_wait_halt: assert property (@(posedge clk) disable iff (!rst_b)
      (st_q == ST_OPC && mem_rdata == OP_WAIT) |=>
      (halted && !flags_q[FLG_I] && !mem_rd))
      else $error("wait did not halt");
endmodule : ctw_exec

// file: dv/tst_mem_model.sv
// Asynchronous-read program memory standing behind the executor's read port
module ctw_mem_model
   import ctw_pkg::*;
(
   input  wire logic        clk,
   input  wire logic [15:0] mem_addr,
   input  wire logic        mem_rd,
   output logic [7:0]       mem_rdata
);
   timeunit 1ns;
   timeprecision 1ps;

   logic [7:0] mem [0:65535];
   logic [7:0] last_q;

   // ==========================================
   // Preload
   initial begin
      for (int i = 0; i < 65536; i++) begin
         mem[i] = 8'h00;
      end
      last_q = 8'h00;
   end

   task automatic poke(input logic [15:0] a, input logic [7:0] d);
      mem[a] = d;
   endtask : poke

   // ==========================================
   // Read port, released line shows inverse of last byte
   always_ff @(posedge clk) begin
      if (mem_rd) begin
         last_q <= mem[mem_addr];
      end
   end

   assign mem_rdata = mem_rd ? mem[mem_addr] : ~last_q;
endmodule : ctw_mem_model

// file: dv/cpu_transfer_test_wait_exec_tb.sv
// Self-checking bench running one program through the executor
module cpu_transfer_test_wait_exec_tb;
   import ctw_pkg::*;
   timeunit 1ns;
   timeprecision 1ps;

   logic        clk;
   logic        rst_b;
   logic        irq_pin;
   logic [15:0] irq_vector;
   logic [7:0]  mem_rdata;
   logic [15:0] mem_addr;
   logic        mem_rd;
   ctw_regs_s   regs;
   logic        halted;
   logic        irq_entry;
   logic        bad_opcode;
   logic        instr_start;
   logic        seen_entry;
   int          mismatches;
   int          checks;
   logic [7:0]  prog [0:19] = '{8'h4D, 8'h85, 8'h97, 8'h5D, 8'h95, 8'h9F, 8'h7D, 8'h6D,
                                8'h05, 8'h3D, 8'h40, 8'h9E, 8'h6D, 8'h10, 8'h85, 8'h97,
                                8'h94, 8'h7D, 8'h84, 8'h8F};

   ctw_exec uut (
      .clk         (clk),
      .rst_b       (rst_b),
      .mem_rdata   (mem_rdata),
      .irq_pin     (irq_pin),
      .irq_vector  (irq_vector),
      .mem_addr    (mem_addr),
      .mem_rd      (mem_rd),
      .regs        (regs),
      .halted      (halted),
      .irq_entry   (irq_entry),
      .bad_opcode  (bad_opcode),
      .instr_start (instr_start)
   );

   ctw_mem_model mem (
      .clk       (clk),
      .mem_addr  (mem_addr),
      .mem_rd    (mem_rd),
      .mem_rdata (mem_rdata)
   );

   // ==========================================
   // Clock and interrupt release
   initial clk = 1'b0;
   always #25 clk = ~clk;

   always @(posedge clk) begin
      if (irq_pin && halted === 1'b0) begin
         irq_pin <= 1'b0;
      end
   end

   // ==========================================
   // Shared tasks
   task automatic check(input logic [47:0] seen, input logic [47:0] exp);
      checks++;
      if (seen !== exp) begin
         mismatches++;
         $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : check

   task automatic exec(input int cyc, input logic [15:0] nxt, input logic [7:0] acc,
                       input logic [15:0] hx, input logic [15:0] stk, input logic [7:0] flg);
      repeat (cyc) @(negedge clk);
      check(48'(mem_addr), 48'(nxt));
      check(48'(regs.pc), 48'(nxt));
      check(48'(instr_start), 48'h0000_0000_0001);
      check({regs.acc, regs.hx, regs.stk, regs.flags}, {acc, hx, stk, flg});
   endtask : exec

   task automatic end_of_test();
      $display("Counts: checks=%0d mismatches=%0d", checks, mismatches);
      if (mismatches == 0 && checks > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask : end_of_test

   // ==========================================
   // Watchdog
   initial begin
      repeat (2000) @(posedge clk);
      mismatches++;
      end_of_test();
   end

   // ==========================================
   // Main sequence
   initial begin
      rst_b      = 1'b0;
      irq_pin    = 1'b0;
      irq_vector = 16'h0080;
      seen_entry = 1'b0;
      mismatches = 0;
      checks     = 0;
      // Preload once the model has cleared its array
      @(negedge clk);
      for (int i = 0; i < 20; i++) begin
         mem.poke(16'(i), prog[i]);
      end
      mem.poke(16'h0080, 8'h9D);
      mem.poke(16'h0081, 8'h85);
      mem.poke(16'h0082, 8'h8F);
      mem.poke(16'h0100, 8'h80);
      mem.poke(16'h0040, 8'hFF);
      mem.poke(16'h010F, 8'h7F);
      check({regs.acc, regs.hx, regs.stk, regs.flags}, {RST_ACC, RST_HX, RST_STK, RST_FLAGS});
      repeat (3) @(posedge clk);
      rst_b <= 1'b1;
      $display("Reset test done");
      @(negedge clk);
      exec(1, 16'h0001, 8'h00, 16'h0000, 16'h00FF, 8'h6A);
      exec(1, 16'h0002, 8'h6A, 16'h0000, 16'h00FF, 8'h6A);
      exec(1, 16'h0003, 8'h6A, 16'h006A, 16'h00FF, 8'h6A);
      exec(1, 16'h0004, 8'h6A, 16'h006A, 16'h00FF, 8'h68);
      exec(2, 16'h0005, 8'h6A, 16'h0100, 16'h00FF, 8'h68);
      exec(1, 16'h0006, 8'h00, 16'h0100, 16'h00FF, 8'h68);
      exec(2, 16'h0007, 8'h00, 16'h0100, 16'h00FF, 8'h6C);
      exec(3, 16'h0009, 8'h00, 16'h0100, 16'h00FF, 8'h6A);
      exec(3, 16'h000B, 8'h00, 16'h0100, 16'h00FF, 8'h6C);
      exec(4, 16'h000E, 8'h00, 16'h0100, 16'h00FF, 8'h68);
      exec(1, 16'h000F, 8'h68, 16'h0100, 16'h00FF, 8'h68);
      exec(1, 16'h0010, 8'h68, 16'h0168, 16'h00FF, 8'h68);
      exec(2, 16'h0011, 8'h68, 16'h0168, 16'h0167, 8'h68);
      exec(2, 16'h0012, 8'h68, 16'h0168, 16'h0167, 8'h6A);
      exec(2, 16'h0013, 8'h68, 16'h0168, 16'h0167, 8'h68);
      $display("Transfer and test sequence done");
      @(negedge clk);
      check(48'(regs.flags), 48'h0000_0000_0060);
      repeat (5) @(negedge clk);
      check({46'h0, halted, mem_rd}, 48'h0000_0000_0002);
      @(posedge clk);
      irq_pin <= 1'b1;
      for (int i = 0; i < 12 && !(instr_start === 1'b1 && mem_addr === 16'h0080); i++) begin
         @(negedge clk);
         if (irq_entry === 1'b1) begin
            seen_entry = 1'b1;
         end
      end
      check(48'(mem_addr), 48'h0000_0000_0080);
      check({46'h0, seen_entry, halted}, 48'h0000_0000_0002);
      exec(1, 16'h0081, 8'h68, 16'h0168, 16'h0167, 8'h68);
      check(48'(bad_opcode), 48'h0000_0000_0001);
      exec(1, 16'h0082, 8'h68, 16'h0168, 16'h0167, 8'h68);
      $display("Wait and wake test done");
      end_of_test();
   end
endmodule : cpu_transfer_test_wait_exec_tb
